// ---- design/iie_pkg.sv ----
// Constants, register map and instruction encodings for the I/O instruction executor.
package iie_pkg;
	localparam int WORD_W = 16;
	localparam int WB_DW = 32;
	localparam int WB_AW = 8;
	localparam int SC_W = 6;
	localparam int CHANNELS = 64;
	localparam int HALF_CH = 32;
	localparam int OP_W = 3;

	// ----------------------------------------------------------------
	// Register byte offsets.
	// ----------------------------------------------------------------
	localparam logic [WB_AW-1:0] REG_INSTR = 8'h00;
	localparam logic [WB_AW-1:0] REG_ACC_A = 8'h04;
	localparam logic [WB_AW-1:0] REG_ACC_B = 8'h08;
	localparam logic [WB_AW-1:0] REG_PC = 8'h0c;
	localparam logic [WB_AW-1:0] REG_STATUS = 8'h10;
	localparam logic [WB_AW-1:0] REG_CONFIG = 8'h14;
	localparam logic [WB_AW-1:0] REG_FLAG_LO = 8'h18;
	localparam logic [WB_AW-1:0] REG_FLAG_HI = 8'h1c;
	localparam logic [WB_AW-1:0] REG_CTL_LO = 8'h20;
	localparam logic [WB_AW-1:0] REG_CTL_HI = 8'h24;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int ST_OVF_BIT = 0;
	localparam int ST_INTR_BIT = 1;
	localparam int ST_HALT_BIT = 2;
	localparam int ST_SKIP_BIT = 3;
	localparam int CFG_MP_BIT = 0;
	localparam int CFG_GLB_BIT = 1;
	localparam int CFG_GSEL_LSB = 8;
	localparam int IR_AB_BIT = 11;
	localparam int IR_HC_BIT = 9;
	localparam int IR_OP_LSB = 6;
	localparam int IR_GRP_BIT = 10;
	localparam int IR_CLASS_LSB = 12;
	localparam logic [3:0] IR_CLASS_IO = 4'h8;

	// ----------------------------------------------------------------
	// Operation field codes and special select codes.
	// ----------------------------------------------------------------
	localparam logic [OP_W-1:0] OP_HALT = 3'h0;
	localparam logic [OP_W-1:0] OP_FLAG = 3'h1;
	localparam logic [OP_W-1:0] OP_SKIP_CLR = 3'h2;
	localparam logic [OP_W-1:0] OP_SKIP_SET = 3'h3;
	localparam logic [OP_W-1:0] OP_MERGE = 3'h4;
	localparam logic [OP_W-1:0] OP_LOAD = 3'h5;
	localparam logic [OP_W-1:0] OP_OUTPUT = 3'h6;
	localparam logic [OP_W-1:0] OP_CONTROL = 3'h7;
	localparam logic [SC_W-1:0] SC_SYSTEM = 6'h00;
	localparam logic [SC_W-1:0] SC_OVERFLOW = 6'h01;
	localparam int SC_FIRST_CARD = 6;
	localparam logic [SC_W-1:0] SC_HC_MIN = 6'h08;

	// ----------------------------------------------------------------
	// Reset values, program counter steps and sequencer states.
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [CHANNELS-1:0] CH_RST = 64'h0;
	localparam logic [WORD_W-1:0] PC_STEP = 16'h0001;
	localparam logic [WORD_W-1:0] PC_SKIP = 16'h0002;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_DONE = 2'b10
	} iie_state_type;
endpackage

// ---- design/iie_top.sv ----
// I/O instruction executor with a classic Wishbone register slave and a backplane port.
// Overview of operation
// - Bit 11 picks accumulator A or B, or set versus clear control.
// - Bit 9 zero keeps the channel flag, one clears it afterwards.
// - Below select code 10 octal the hold/clear bit leaves flags alone.
// - Bits 8 to 6 choose the I/O operation.
// - Global mode: bits 5..0 are a register number on the global card.
// - No I/O instruction executes while memory protect is enabled.
// - Clear control resets the addressed control bit, stopping its interrupts.
// - Clear control at select code 00 resets control bits 06 and up.
// - Clear flag resets a flag; at 00 it disables the interrupt system.
// - Set flag sets a flag; at 00 it enables the interrupt system.
// - Set control sets the addressed control bit.
// - Clear overflow resets the overflow bit; set overflow sets it.
// - Halt stops, holds or clears flag, saves word and PC plus one.
// - Halt does nothing when no card has break enabled.
// - Load input replaces an accumulator with the word the card drives.
// - Merge input ORs the card word into an accumulator.
// - Output sends an accumulator to the card, accumulator unchanged.
// - Skip when the addressed flag is clear.
// - Skip when the addressed flag is set.
// - Skip when overflow clear; bit 9 then keeps or clears overflow.
// - Skip when overflow set; bit 9 then keeps or clears overflow.
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module iie_top (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [iie_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [iie_pkg::WB_DW-1:0] wb_dat_i,
	output logic [iie_pkg::WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Backplane toward the interface cards.
	input wire logic [iie_pkg::WORD_W-1:0] io_dat_i,
	input wire logic [iie_pkg::CHANNELS-1:0] flag_set_i,
	input wire logic break_any_i,
	output logic [iie_pkg::SC_W-1:0] io_sel_o,
	output logic [iie_pkg::SC_W-1:0] io_reg_o,
	output logic [iie_pkg::WORD_W-1:0] io_dat_o,
	output logic io_rd_o,
	output logic io_wr_o,
	// Channel state and processor status.
	output logic [iie_pkg::CHANNELS-1:0] ctl_o,
	output logic [iie_pkg::CHANNELS-1:0] flag_o,
	output logic intr_en_o,
	output logic overflow_o,
	output logic halt_o,
	output logic panel_start_o
);
	import iie_pkg::*;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	// Merges a bus write into a register honouring the byte lanes.
	function automatic logic [WB_DW-1:0] lane_merge(input logic [WB_DW-1:0] old_v,
		input logic [WB_DW-1:0] new_v, input logic [3:0] sel);
		logic [WB_DW-1:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			res[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
		return res;
	endfunction
	// True when the word belongs to the I/O instruction group.
	function automatic logic is_io(input logic [WORD_W-1:0] w);
		return (w[WORD_W-1:IR_CLASS_LSB] == IR_CLASS_IO) && w[IR_GRP_BIT];
	endfunction
	// Channel addressed by a word: global card in global mode, else bits 5..0.
	function automatic logic [SC_W-1:0] chan_of(input logic [WORD_W-1:0] w, input logic gen,
		input logic [SC_W-1:0] gsel);
		return gen ? gsel : w[SC_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	iie_state_type state;
	logic [WORD_W-1:0] ir, acc_a, acc_b, pc, wb_word;
	logic mem_protect, global_en, last_skip, bus_req, wr_hit, start_exec;
	logic [SC_W-1:0] global_sel, sc;
	logic [OP_W-1:0] op;
	logic next_overflow, next_intr, next_skip, next_halt;
	logic [WORD_W-1:0] next_acc_a, next_acc_b;
	logic [CHANNELS-1:0] next_flag, next_ctl;
	logic [WB_DW-1:0] next_rdata;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && state == ST_IDLE;
	assign wr_hit = bus_req && wb_we_i;
	assign wb_word = wb_dat_i[WORD_W-1:0];
	// A suppressed or foreign word is acknowledged but never reaches the sequencer.
	assign start_exec = wr_hit && wb_adr_i == REG_INSTR && (&wb_sel_i[1:0]) && is_io(wb_word)
		&& !mem_protect && !halt_o;
	assign op = ir[IR_OP_LSB +: OP_W];
	assign sc = chan_of(ir, global_en, global_sel);

	// ----------------------------------------------------------------
	// Execution of the latched instruction.
	// ----------------------------------------------------------------
	// Evaluated during the issue cycle, when the card already drives its word.
	always_comb begin
		next_overflow = overflow_o;
		next_intr = intr_en_o;
		next_skip = 1'b0;
		next_halt = 1'b0;
		next_acc_a = acc_a;
		next_acc_b = acc_b;
		next_flag = flag_o;
		next_ctl = ctl_o;
		case (op)
			OP_HALT: next_halt = break_any_i;
			OP_FLAG: begin
				if (sc == SC_SYSTEM) begin
					next_intr = !ir[IR_HC_BIT];
				end else if (sc == SC_OVERFLOW) begin
					next_overflow = !ir[IR_HC_BIT];
				end else begin
					next_flag[sc] = !ir[IR_HC_BIT];
				end
			end
			OP_SKIP_CLR: next_skip = (sc == SC_OVERFLOW) ? !overflow_o : !flag_o[sc];
			OP_SKIP_SET: next_skip = (sc == SC_OVERFLOW) ? overflow_o : flag_o[sc];
			OP_MERGE: begin
				if (ir[IR_AB_BIT]) begin
					next_acc_b = acc_b | io_dat_i;
				end else begin
					next_acc_a = acc_a | io_dat_i;
				end
			end
			OP_LOAD: begin
				if (ir[IR_AB_BIT]) begin
					next_acc_b = io_dat_i;
				end else begin
					next_acc_a = io_dat_i;
				end
			end
			OP_OUTPUT: next_skip = 1'b0;
			OP_CONTROL: begin
				if (sc == SC_SYSTEM && ir[IR_AB_BIT]) begin
					for (int c = SC_FIRST_CARD; c < CHANNELS; c++) begin
						next_ctl[c] = 1'b0;
					end
				end else begin
					next_ctl[sc] = !ir[IR_AB_BIT];
				end
			end
			default: next_skip = 1'b0;
		endcase
		// Hold/clear after execution; the flag group uses bit 9 as its own opcode.
		if (op != OP_FLAG && ir[IR_HC_BIT]) begin
			if (sc == SC_OVERFLOW && (op == OP_SKIP_CLR || op == OP_SKIP_SET)) begin
				next_overflow = 1'b0;
			end else if (sc >= SC_HC_MIN && !(op == OP_HALT && !break_any_i)) begin
				next_flag[sc] = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus sequencer and acknowledge.
	// ----------------------------------------------------------------
	// Executed instruction writes take one extra cycle so the card can answer the strobe.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			wb_ack_o <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_exec) begin
						state <= ST_ISSUE;
					end else if (bus_req) begin
						state <= ST_DONE;
						wb_ack_o <= 1'b1;
					end
				end
				ST_ISSUE: begin
					state <= ST_DONE;
					wb_ack_o <= 1'b1;
				end
				ST_DONE: begin
					state <= ST_IDLE;
					wb_ack_o <= 1'b0;
				end
				default: begin
					state <= ST_IDLE;
					wb_ack_o <= 1'b0;
				end
			endcase
		end
	end

	// Read data is captured when the access is first seen; unmapped reads give zero.
	always_comb begin
		next_rdata = '0;
		case (wb_adr_i)
			REG_INSTR: next_rdata[WORD_W-1:0] = ir;
			REG_ACC_A: next_rdata[WORD_W-1:0] = acc_a;
			REG_ACC_B: next_rdata[WORD_W-1:0] = acc_b;
			REG_PC: next_rdata[WORD_W-1:0] = pc;
			REG_STATUS: begin
				next_rdata[ST_OVF_BIT] = overflow_o;
				next_rdata[ST_INTR_BIT] = intr_en_o;
				next_rdata[ST_HALT_BIT] = halt_o;
				next_rdata[ST_SKIP_BIT] = last_skip;
			end
			REG_CONFIG: begin
				next_rdata[CFG_MP_BIT] = mem_protect;
				next_rdata[CFG_GLB_BIT] = global_en;
				next_rdata[CFG_GSEL_LSB +: SC_W] = global_sel;
			end
			REG_FLAG_LO: next_rdata = flag_o[HALF_CH-1:0];
			REG_FLAG_HI: next_rdata = flag_o[CHANNELS-1:HALF_CH];
			REG_CTL_LO: next_rdata = ctl_o[HALF_CH-1:0];
			REG_CTL_HI: next_rdata = ctl_o[CHANNELS-1:HALF_CH];
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Backplane strobes.
	// ----------------------------------------------------------------
	// Strobes stand for exactly the issue cycle; address and data hold until the next instruction.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			io_sel_o <= '0;
			io_reg_o <= '0;
			io_dat_o <= WORD_RST;
			io_rd_o <= 1'b0;
			io_wr_o <= 1'b0;
		end else if (start_exec) begin
			io_sel_o <= chan_of(wb_word, global_en, global_sel);
			io_reg_o <= global_en ? wb_word[SC_W-1:0] : SC_SYSTEM;
			io_dat_o <= wb_word[IR_AB_BIT] ? acc_b : acc_a;
			io_rd_o <= wb_word[IR_OP_LSB +: OP_W] == OP_LOAD || wb_word[IR_OP_LSB +: OP_W] == OP_MERGE;
			io_wr_o <= wb_word[IR_OP_LSB +: OP_W] == OP_OUTPUT;
		end else begin
			io_rd_o <= 1'b0;
			io_wr_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Instruction word and program counter.
	// ----------------------------------------------------------------
	// The instruction register doubles as the word shown to the front panel on halt.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir <= WORD_RST;
		end else if (start_exec) begin
			ir <= wb_word;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc <= WORD_RST;
			last_skip <= 1'b0;
		end else if (state == ST_ISSUE) begin
			pc <= pc + (next_skip ? PC_SKIP : PC_STEP);
			last_skip <= next_skip;
		end else if (wr_hit && wb_adr_i == REG_PC) begin
			pc <= WORD_W'(lane_merge(WB_DW'(pc), wb_dat_i, wb_sel_i));
		end
	end

	// ----------------------------------------------------------------
	// Accumulators.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_a <= WORD_RST;
			acc_b <= WORD_RST;
		end else if (state == ST_ISSUE) begin
			acc_a <= next_acc_a;
			acc_b <= next_acc_b;
		end else if (wr_hit && wb_adr_i == REG_ACC_A) begin
			acc_a <= WORD_W'(lane_merge(WB_DW'(acc_a), wb_dat_i, wb_sel_i));
		end else if (wr_hit && wb_adr_i == REG_ACC_B) begin
			acc_b <= WORD_W'(lane_merge(WB_DW'(acc_b), wb_dat_i, wb_sel_i));
		end
	end

	// ----------------------------------------------------------------
	// Channel flags and control bits.
	// ----------------------------------------------------------------
	// A card raising its flag in the cycle an instruction clears it still wins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= CH_RST;
		end else if (state == ST_ISSUE) begin
			flag_o <= next_flag | flag_set_i;
		end else begin
			flag_o <= flag_o | flag_set_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_o <= CH_RST;
		end else if (state == ST_ISSUE) begin
			ctl_o <= next_ctl;
		end
	end

	// ----------------------------------------------------------------
	// Overflow, interrupt system and halt.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_o <= 1'b0;
			intr_en_o <= 1'b0;
		end else if (state == ST_ISSUE) begin
			overflow_o <= next_overflow;
			intr_en_o <= next_intr;
		end else if (wr_hit && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
			overflow_o <= wb_dat_i[ST_OVF_BIT];
		end
	end

	// Halt is sticky until software writes one to its status bit.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_o <= 1'b0;
			panel_start_o <= 1'b0;
		end else begin
			panel_start_o <= state == ST_ISSUE && op == OP_HALT && next_halt;
			if (state == ST_ISSUE && op == OP_HALT && next_halt) begin
				halt_o <= 1'b1;
			end else if (wr_hit && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[ST_HALT_BIT]) begin
				halt_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_protect <= 1'b0;
			global_en <= 1'b0;
			global_sel <= '0;
		end else if (wr_hit && wb_adr_i == REG_CONFIG) begin
			if (wb_sel_i[0]) begin
				mem_protect <= wb_dat_i[CFG_MP_BIT];
				global_en <= wb_dat_i[CFG_GLB_BIT];
			end
			if (wb_sel_i[1]) begin
				global_sel <= wb_dat_i[CFG_GSEL_LSB +: SC_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	a_protect_blocks_io: assert property (mem_protect && state == ST_IDLE |=> !io_rd_o && !io_wr_o)
		else $error("backplane strobe while memory protect is enabled");
	a_output_keeps_acc: assert property (io_wr_o |=> $stable(acc_a) && $stable(acc_b))
		else $error("output instruction altered an accumulator");
	a_load_takes_word: assert property (io_rd_o && op == OP_LOAD && !ir[IR_AB_BIT]
		|=> acc_a == $past(io_dat_i))
		else $error("load input did not take the card word");
	a_skip_pc_step: assert property (state == ST_ISSUE && next_skip |=> pc == $past(pc) + PC_SKIP)
		else $error("taken skip did not advance by two");
	a_clear_all_ctl: assert property (state == ST_ISSUE && op == OP_CONTROL && sc == SC_SYSTEM
		&& ir[IR_AB_BIT] |=> ctl_o[CHANNELS-1:SC_FIRST_CARD] == '0
		&& ctl_o[SC_FIRST_CARD-1:0] == $past(ctl_o[SC_FIRST_CARD-1:0]))
		else $error("clear control at 00 misbehaved");
	a_halt_needs_break: assert property ($rose(halt_o) |-> $past(break_any_i) && panel_start_o)
		else $error("halt without break or without front panel start");
	a_ovf_skip_clear: assert property (state == ST_ISSUE && sc == SC_OVERFLOW && op == OP_SKIP_SET
		&& ir[IR_HC_BIT] |=> !overflow_o)
		else $error("overflow not cleared after skip with clear option");
	a_set_flag_wins: assert property (flag_set_i != '0 |=> (flag_o & $past(flag_set_i)) == $past(flag_set_i))
		else $error("card flag set was lost");
endmodule

// ---- verif/iie_card_model.sv ----
// Behavioural interface card that answers the executor's backplane strobes.
`timescale 1ns/1ps
module iie_card_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Strobes and data from the executor.
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [15:0] wr_dat_i,
	// Word the card presents, and the word it captured.
	input wire logic [15:0] word_i,
	output logic [15:0] rd_dat_o,
	output logic [15:0] got_o
);
	logic [15:0] last;

	// The card drives only during a read strobe; otherwise it shows the inverse of its last word.
	always_comb begin
		rd_dat_o = rd_i ? word_i : ~last;
	end

	// Captures output words and remembers the last driven word.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last <= 16'h0000;
			got_o <= 16'h0000;
		end else begin
			if (rd_i) last <= word_i;
			if (wr_i) got_o <= wr_dat_i;
		end
	end
endmodule

// ---- verif/test_iie_top.sv ----
// Self-checking testbench for the I/O instruction executor.
`timescale 1ns/1ps
module test_iie_top;
	import iie_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [WB_AW-1:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [WB_DW-1:0] wdat = 32'h0;
	logic [WB_DW-1:0] rdat;
	logic ack;
	logic [WORD_W-1:0] io_in;
	logic [WORD_W-1:0] io_out;
	logic [WORD_W-1:0] card_word = 16'h0000;
	logic [WORD_W-1:0] card_got;
	logic [CHANNELS-1:0] flag_set = 64'h0;
	logic [CHANNELS-1:0] ctl;
	logic [CHANNELS-1:0] flag;
	logic brk = 1'b0;
	logic [SC_W-1:0] io_sel;
	logic [SC_W-1:0] io_reg;
	logic io_rd, io_wr, intr_en, ovf, halted, panel;
	logic [31:0] q;
	int n_errors = 0;
	int compares = 0;
	int n_panel = 0;

	// Free-running 50 MHz clock.
	always #10 clk_i = ~clk_i;

	iie_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.io_dat_i(io_in), .flag_set_i(flag_set), .break_any_i(brk), .io_sel_o(io_sel),
		.io_reg_o(io_reg), .io_dat_o(io_out), .io_rd_o(io_rd), .io_wr_o(io_wr), .ctl_o(ctl),
		.flag_o(flag), .intr_en_o(intr_en), .overflow_o(ovf), .halt_o(halted), .panel_start_o(panel));

	iie_card_model card (.clk_i(clk_i), .rst_i(rst_i), .rd_i(io_rd), .wr_i(io_wr),
		.wr_dat_i(io_out), .word_i(card_word), .rd_dat_o(io_in), .got_o(card_got));

	// Counts front-panel start pulses, which last a single cycle.
	always @(posedge clk_i) begin
		if (panel === 1'b1) n_panel <= n_panel + 1;
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One classic cycle; the request holds until ack is sampled, and the wait is bounded.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) chk(64'h0, 64'h1);
	endtask

	function automatic logic [15:0] ins(input logic ab, input logic hc, input logic [2:0] op,
		input logic [5:0] sc);
		return {IR_CLASS_IO, ab, 1'b1, hc, op, sc};
	endfunction

	task automatic exec(input logic [15:0] w);
		wb(1'b1, REG_INSTR, {16'h0, w}, q);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, q);
		chk(64'(q), 64'(e));
	endtask

	// Runs a skip and checks how far the program counter moved.
	task automatic skp(input logic [15:0] w, input logic taken);
		logic [31:0] p;
		wb(1'b0, REG_PC, 32'h0, p);
		exec(w);
		rdchk(REG_PC, p + (taken ? 32'h2 : 32'h1));
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_control;
		exec(ins(1'b0, 1'b0, OP_CONTROL, 6'h0a));
		exec(ins(1'b0, 1'b0, OP_CONTROL, 6'h05));
		exec(ins(1'b0, 1'b0, OP_CONTROL, 6'h06));
		exec(ins(1'b0, 1'b0, OP_CONTROL, 6'h3f));
		chk(ctl, 64'h8000_0000_0000_0460);
		exec(ins(1'b1, 1'b0, OP_CONTROL, 6'h0a));
		chk(ctl, 64'h8000_0000_0000_0060);
		exec(ins(1'b1, 1'b0, OP_CONTROL, SC_SYSTEM));
		chk(ctl, 64'h20);
		$display("test control done");
	endtask

	task automatic t_flag;
		exec(ins(1'b0, 1'b0, OP_FLAG, 6'h0c));
		chk(flag, 64'h1000);
		@(posedge clk_i) flag_set[32] <= 1'b1;
		@(posedge clk_i) flag_set[32] <= 1'b0;
		@(posedge clk_i);
		exec(ins(1'b0, 1'b1, OP_FLAG, 6'h0c));
		chk(flag, 64'h1_0000_0000);
		exec(ins(1'b0, 1'b0, OP_FLAG, SC_SYSTEM));
		chk({intr_en, flag[62:0]}, 64'h8000_0001_0000_0000);
		exec(ins(1'b0, 1'b1, OP_FLAG, SC_SYSTEM));
		chk({intr_en, flag[62:0]}, 64'h1_0000_0000);
		exec(ins(1'b0, 1'b1, OP_FLAG, 6'h20));
		chk(flag, 64'h0);
		exec(ins(1'b0, 1'b0, OP_FLAG, SC_OVERFLOW));
		chk(64'(ovf), 64'h1);
		exec(ins(1'b0, 1'b1, OP_FLAG, SC_OVERFLOW));
		chk(64'(ovf), 64'h0);
		$display("test flag done");
	endtask

	task automatic t_skip;
		skp(ins(1'b0, 1'b0, OP_SKIP_CLR, 6'h0c), 1'b1);
		skp(ins(1'b0, 1'b0, OP_SKIP_SET, 6'h0c), 1'b0);
		exec(ins(1'b0, 1'b0, OP_FLAG, 6'h0c));
		skp(ins(1'b0, 1'b1, OP_SKIP_SET, 6'h0c), 1'b1);
		chk(flag, 64'h0);
		exec(ins(1'b0, 1'b0, OP_FLAG, 6'h05));
		skp(ins(1'b0, 1'b1, OP_SKIP_SET, 6'h05), 1'b1);
		chk(flag, 64'h20);
		skp(ins(1'b0, 1'b0, OP_SKIP_CLR, 6'h05), 1'b0);
		skp(ins(1'b0, 1'b0, OP_SKIP_CLR, SC_OVERFLOW), 1'b1);
		exec(ins(1'b0, 1'b0, OP_FLAG, SC_OVERFLOW));
		skp(ins(1'b0, 1'b0, OP_SKIP_CLR, SC_OVERFLOW), 1'b0);
		chk(64'(ovf), 64'h1);
		skp(ins(1'b0, 1'b1, OP_SKIP_SET, SC_OVERFLOW), 1'b1);
		chk(64'(ovf), 64'h0);
		$display("test skip done");
	endtask

	task automatic t_data;
		wb(1'b1, REG_ACC_A, 32'h1234, q);
		card_word <= 16'h00f0;
		exec(ins(1'b0, 1'b0, OP_LOAD, 6'h0b));
		rdchk(REG_ACC_A, 32'h00f0);
		chk(64'({io_sel, io_reg}), 64'h2c0);
		wb(1'b1, REG_ACC_B, 32'h0f01, q);
		card_word <= 16'h8030;
		exec(ins(1'b1, 1'b0, OP_MERGE, 6'h0c));
		rdchk(REG_ACC_B, 32'h8f31);
		exec(ins(1'b1, 1'b0, OP_OUTPUT, 6'h0d));
		chk(64'(card_got), 64'h8f31);
		rdchk(REG_ACC_B, 32'h8f31);
		exec(ins(1'b0, 1'b0, OP_OUTPUT, 6'h0d));
		chk(64'(card_got), 64'h00f0);
		$display("test data done");
	endtask

	// Global addressing, then memory protect blocking execution.
	task automatic t_global;
		logic [31:0] p;
		wb(1'b1, REG_CONFIG, 32'h1502, q);
		exec(ins(1'b0, 1'b0, OP_LOAD, 6'h03));
		chk(64'({io_sel, io_reg}), 64'h543);
		exec(ins(1'b0, 1'b0, OP_CONTROL, 6'h03));
		chk(ctl, 64'h20_0020);
		wb(1'b1, REG_CONFIG, 32'h1, q);
		wb(1'b0, REG_PC, 32'h0, p);
		exec(ins(1'b0, 1'b0, OP_CONTROL, 6'h30));
		chk(ctl, 64'h20_0020);
		rdchk(REG_PC, p);
		wb(1'b1, REG_CONFIG, 32'h0, q);
		$display("test global done");
	endtask

	task automatic t_halt;
		logic [31:0] p;
		exec(ins(1'b0, 1'b0, OP_FLAG, 6'h0c));
		exec(ins(1'b0, 1'b1, OP_HALT, 6'h0c));
		chk({halted, flag[62:0]}, 64'h1020);
		brk <= 1'b1;
		wb(1'b0, REG_PC, 32'h0, p);
		exec(ins(1'b0, 1'b1, OP_HALT, 6'h0c));
		rdchk(REG_INSTR, 32'(ins(1'b0, 1'b1, OP_HALT, 6'h0c)));
		chk(64'({halted, n_panel[3:0]}), 64'h11);
		rdchk(REG_PC, p + 32'h1);
		chk(flag, 64'h20);
		wb(1'b1, REG_STATUS, 32'h4, q);
		chk(64'(halted), 64'h0);
		$display("test halt done");
	endtask

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence: reset for four cycles, then every scenario.
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_control();
		t_flag();
		t_skip();
		t_data();
		t_global();
		t_halt();
		stop_test();
	end

	// Watchdog well beyond the few hundred bus cycles the scenarios need.
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		stop_test();
	end
endmodule
